/* core/sacc_conv_ctrl.sv */
// Purpose: Start, busy and bit sequencing with parallel result hand-off
// Assumes: conversion_start_n and compareIn come from outside the clock
// Notes:   Internal clk_sys stands in for the converter's own clock
`include "sacc_params.svh"
`default_nettype none

// Contract
// R01: Falling start edge begins a conversion
// R02: Start edges during conversion are ignored
// R03: Result register cleared before bit decisions
// R04: Busy low while converting, high otherwise
// R05: Bits decided MSB first to LSB
// R06: Completed result loaded into output latches
// R07: Data valid at busy rising edge
// R08: Cycle completes within 454 ns; busy here stays low for 16 clk_sys cycles, 640 ns
// R09: Controller allows 70 ns acquisition; here busy can fall again one clk_sys cycle (40 ns) after it rises
// R10: Start returns high early or after busy
// R11: Steps timed from internal clock
// R12: Controller captures result at busy rise
module sacc_conv_ctrl
    import sacc_pkg::*;
(
    input  wire logic        clk_sys,            // 25 MHz clock
    input  wire logic        rst,                // Async reset, high
    input  wire logic        clkEn,              // Freeze when low
    input  wire logic        conversion_start_n, // Start pin, active low
    input  wire logic        compareIn,          // Comparator decision
    output logic             busy_n,             // Low while converting
    output logic      [13:0] result_bits,        // Parallel result
    output logic             dacActive,          // Trial bit in DAC
    output logic      [13:0] dacTrial,           // Trial word to DAC
    output logic      [13:0] fifoData,           // Buffered result
    output logic             fifoValid,          // Buffered result valid
    input  wire logic        fifoReady,          // Reader takes word
    output logic             overrun             // Result dropped
);
    // ********************************************************
    // Input synchronisers
    // ********************************************************
    logic [1:0] pinSync;
    logic       startSync;
    logic       startPrev;
    logic       cmpSync;
    logic       startFall;

    // Start idles high so reset leaves no false edge
    sacc_sync2 #(
        .WIDTH   (2),
        .RST_VAL (2'b10)
    ) sacc_sync2_i (
        .clk_sys (clk_sys),
        .rst     (rst),
        .clkEn   (clkEn),
        .pinIn   ({conversion_start_n, compareIn}),
        .syncOut (pinSync)
    );
    assign startSync = pinSync[1];
    assign cmpSync   = pinSync[0];

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            startPrev <= 1'b1;
        end else if (clkEn) begin
            startPrev <= startSync;
        end
    end

    assign startFall = startPrev && !startSync; // R01

    // ********************************************************
    // Sequencer
    // ********************************************************
    sacc_state_t state;
    sacc_word_t  approximation_result_register;
    logic [3:0]  bitIdx;
    logic        fifoInReady;
    logic        loadPulse;

    // Clear + 14 decisions + load must not exceed SACC_CONV_CYC + 6 cycles
    localparam int STEPS = `SACC_RES_BITS + 2;
    if (STEPS > `SACC_CONV_CYC + 6) begin : g_budget
        $error("Conversion steps exceed throughput budget");
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state  <= SACC_IDLE;
            bitIdx <= 4'h0;
        end else if (clkEn) begin
            case (state) // R11
                SACC_IDLE: begin
                    if (startFall) begin // R01
                        state <= SACC_CLEAR;
                    end
                end
                SACC_CLEAR: begin
                    bitIdx <= 4'(`SACC_RES_BITS - 1);
                    state  <= SACC_DECIDE;
                end
                SACC_DECIDE: begin
                    // Start edges not looked at here
                    // Decision lags its trial by the sync delay
                    if (bitIdx == 4'h0) begin // R02 R05
                        state <= SACC_LOAD;
                    end else begin
                        bitIdx <= bitIdx - 4'h1;
                    end
                end
                SACC_LOAD: begin
                    state <= SACC_IDLE; // R08
                end
                default: begin
                    state <= SACC_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            approximation_result_register <= `SACC_RESULT_RST;
        end else if (clkEn) begin
            if (state == SACC_CLEAR) begin
                approximation_result_register <= `SACC_RESULT_RST; // R03
            end else if (state == SACC_DECIDE) begin
                approximation_result_register[bitIdx] <= cmpSync; // R05
            end
        end
    end

    // Trial word: decided bits, current bit set, lower bits clear
    always_comb begin
        dacTrial = approximation_result_register;
        if (state == SACC_DECIDE) begin
            dacTrial[bitIdx] = 1'b1;
        end
    end
    assign dacActive = (state == SACC_DECIDE);

    // ********************************************************
    // Output latches and busy
    // ********************************************************
    assign loadPulse = clkEn && (state == SACC_LOAD);

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            result_bits <= `SACC_RESULT_RST;
        end else if (loadPulse) begin
            result_bits <= approximation_result_register; // R06
        end
    end

    // Busy rises on the same edge the latches load
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            busy_n <= 1'b1;
        end else if (clkEn) begin
            if (state == SACC_IDLE && startFall) begin
                busy_n <= 1'b0; // R04
            end else if (state == SACC_LOAD) begin
                busy_n <= 1'b1; // R04 R07
            end
        end
    end

    // ********************************************************
    // Result FIFO
    // ********************************************************
    // Full FIFO drops the new word and flags it; the pin latch
    // still updates so the parallel port never stalls.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            overrun <= 1'b0;
        end else if (loadPulse) begin
            overrun <= !fifoInReady;
        end
    end

    sacc_fifo #(
        .WIDTH (`SACC_RES_BITS),
        .DEPTH (`SACC_FIFO_DEPTH)
    ) sacc_fifo_i (
        .clk_sys  (clk_sys),
        .rst      (rst),
        .clkEn    (clkEn),
        .inData   (approximation_result_register),
        .inValid  (state == SACC_LOAD),
        .inReady  (fifoInReady),
        .outData  (fifoData),
        .outValid (fifoValid),
        .outReady (fifoReady)
    );
endmodule : sacc_conv_ctrl

// ********************************************************
// Two-flop synchroniser
// ********************************************************
// Only the second flop is read, so metastability stays inside
module sacc_sync2 #(
    parameter int               WIDTH   = 2,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input  wire logic             clk_sys, // System clock
    input  wire logic             rst,     // Async reset, high
    input  wire logic             clkEn,   // Freeze when low
    input  wire logic [WIDTH-1:0] pinIn,   // Asynchronous levels
    output logic      [WIDTH-1:0] syncOut  // Synchronised levels
);
    logic [WIDTH-1:0] meta;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            meta    <= RST_VAL;
            syncOut <= RST_VAL;
        end else if (clkEn) begin
            meta    <= pinIn;
            syncOut <= meta;
        end
    end
endmodule : sacc_sync2
`default_nettype wire

/* core/sacc_params.svh */
// Purpose: Constants for the conversion sequencer
// Assumes: clk_sys at 25 MHz (40 ns)
// Notes:   Times in ns, counts derived from them
`ifndef SACC_PARAMS_SVH
`define SACC_PARAMS_SVH

`define SACC_CLK_NS          40
`define SACC_RES_BITS        14
`define SACC_FIFO_DEPTH      4
`define SACC_RESULT_RST      14'h0000
// Conversion time, maximum 400 ns; longest time rounds down
`define SACC_TCONV_NS        400
`define SACC_CONV_CYC        ((`SACC_TCONV_NS) / (`SACC_CLK_NS))
// Throughput maximum 454 ns, typical 370 ns
`define SACC_TTHRU_MAX_NS    454
`define SACC_TTHRU_TYP_NS    370
// Acquisition the controller must allow, 70 ns
`define SACC_TACQ_NS         70
`define SACC_ACQ_CYC         \
    (((`SACC_TACQ_NS) + (`SACC_CLK_NS) - 1) / (`SACC_CLK_NS))
// Data valid window around busy rise, +/-20 ns
`define SACC_TDATA_NS        20
`define SACC_TSTARTHI_NS     225

`endif

/* core/sacc_pkg.sv */
// Purpose: Types for the conversion sequencer
// Assumes: Nothing beyond the params header
// Notes:   States Gray coded along the usual path
`default_nettype none
package sacc_pkg;
    typedef enum logic [1:0] {
        SACC_IDLE    = 2'b00,
        SACC_CLEAR   = 2'b01,
        SACC_DECIDE  = 2'b11,
        SACC_LOAD    = 2'b10
    } sacc_state_t;
    typedef logic [13:0] sacc_word_t;
endpackage : sacc_pkg
`default_nettype wire

/* core/sacc_fifo.sv */
// Purpose: Small result FIFO with valid/ready on both sides
// Assumes: Single clock
// Notes:   Full and empty are exact
`default_nettype none
module sacc_fifo #(
    parameter int WIDTH = 14,
    parameter int DEPTH = 4
) (
    input  wire logic             clk_sys,  // System clock
    input  wire logic             rst,      // Async reset
    input  wire logic             clkEn,    // Freeze when low
    input  wire logic [WIDTH-1:0] inData,   // Write data
    input  wire logic             inValid,  // Write request
    output logic                  inReady,  // Not full
    output logic      [WIDTH-1:0] outData,  // Head word
    output logic                  outValid, // Not empty
    input  wire logic             outReady  // Reader takes
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wrPtr;
    logic [AW-1:0]    rdPtr;
    logic [AW:0]      count;
    logic             doWr;
    logic             doRd;

    assign inReady  = (count != (AW+1)'(DEPTH));
    assign outValid = (count != '0);
    assign doWr     = clkEn && inValid && inReady;
    assign doRd     = clkEn && outValid && outReady;
    assign outData  = mem[rdPtr];

    always_ff @(posedge clk_sys) begin
        if (doWr) begin
            mem[wrPtr] <= inData;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            wrPtr <= '0;
            rdPtr <= '0;
            count <= '0;
        end else begin
            if (doWr) begin
                wrPtr <= wrPtr + 1'b1;
            end
            if (doRd) begin
                rdPtr <= rdPtr + 1'b1;
            end
            if (doWr && !doRd) begin
                count <= count + 1'b1;
            end else if (doRd && !doWr) begin
                count <= count - 1'b1;
            end
        end
    end
endmodule : sacc_fifo
`default_nettype wire

/* tb/sacc_conv_sva.sv */
// Purpose: Port checks for the conversion sequencer
// Assumes: Checks pause while clkEn is low, except freeze_hold_a
// Notes:   Edge counts taken from the sampled busy fall, in start_busy_a from the sampled start fall
`default_nettype none
module sacc_conv_sva (
    input wire logic        clk_sys,            // Clock
    input wire logic        rst,                // Reset
    input wire logic        clkEn,              // Clock enable
    input wire logic        conversion_start_n, // Start pin
    input wire logic        busy_n,             // Busy
    input wire logic [13:0] result_bits,        // Latches
    input wire logic        dacActive,          // Deciding
    input wire logic [13:0] dacTrial,           // Trial word
    input wire logic        fifoValid,          // Buffered
    input wire logic        overrun             // Dropped
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst || !clkEn);
    freeze_hold_a: assert property (disable iff (rst)
        !clkEn |=> $stable(busy_n) && $stable(result_bits))
        else $error("state moved while frozen");
    start_busy_a: assert property (
        $fell(conversion_start_n) && busy_n |-> ##4 !busy_n)
        else $error("busy did not follow start");
    busy_len_a: assert property (
        $fell(busy_n) |-> !busy_n[*8] ##1 !busy_n[*8] ##1 busy_n)
        else $error("busy low span wrong");
    step_order_a: assert property (
        $fell(busy_n) |-> !dacActive ##1 dacActive[*8] ##1
        dacActive[*6] ##1 !dacActive) else $error("decide steps wrong");
    sar_clear_a: assert property (
        $fell(busy_n) |-> ##1 dacTrial == 14'h2000)
        else $error("first trial not msb");
    lsb_last_a: assert property (
        $fell(busy_n) |-> ##14 dacTrial[0])
        else $error("last trial not lsb");
    latch_time_a: assert property (
        $changed(result_bits) |-> $rose(busy_n))
        else $error("result moved off busy rise");
    hand_off_a: assert property (
        $rose(busy_n) |-> fifoValid) else $error("no buffered word");
    overrun_set_a: assert property (
        $rose(overrun) |-> $rose(busy_n)) else $error("stray overrun");
endmodule : sacc_conv_sva
`default_nettype wire

/* tb/sacc_ctl_model.sv */
// Purpose: Controller that starts conversions and takes results
// Assumes: Called from the bench one conversion at a time
// Notes:   Glitch option drops the pin again mid-conversion
`default_nettype none
module sacc_ctl_model (
    input  wire logic        clk_sys,            // Clock
    input  wire logic        busy_n,             // Busy
    input  wire logic [13:0] result_bits,        // Latches
    output var  logic        conversion_start_n  // Start pin
);
    timeunit 1ns;
    timeprecision 1ps;
    initial conversion_start_n = 1'b1;
    task automatic convert(input logic glitch, output logic [13:0] d);
        int n;
        n = 0;
        repeat (2) @(posedge clk_sys);
        conversion_start_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        conversion_start_n <= 1'b1;
        if (glitch) begin
            // Stray start mid-conversion, back high within 225 ns
            @(posedge clk_sys);
            conversion_start_n <= 1'b0;
            repeat (2) @(posedge clk_sys);
            conversion_start_n <= 1'b1;
        end
        do begin @(negedge clk_sys); n++; end
        while (busy_n !== 1'b0 && n < 8);
        do begin @(negedge clk_sys); n++; end
        while (busy_n !== 1'b1 && n < 40);
        d = result_bits;
    endtask : convert
endmodule : sacc_ctl_model
`default_nettype wire

/* tb/sar_adc_conversion_control_bench.sv */
// Purpose: Self-checking bench for the conversion sequencer
// Assumes: Comparator held steady per conversion
// Notes:   clkEn dropped mid-conversion to test the freeze
`default_nettype none
module sar_adc_conversion_control_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_sys, rst, compareIn, fifoReady, startN, busy_n;
    logic        dacActive, fifoValid, overrun;
    logic        clkEn;
    logic [13:0] result_bits, dacTrial, fifoData, d;
    int          n_mismatch = 0;
    int          total_checks = 0;
    sacc_conv_ctrl sacc_conv_ctrl_i (.clk_sys, .rst, .clkEn,
        .conversion_start_n(startN), .compareIn, .busy_n, .result_bits,
        .dacActive, .dacTrial, .fifoData, .fifoValid, .fifoReady,
        .overrun);
    sacc_ctl_model sacc_ctl_model_i (.clk_sys, .busy_n, .result_bits,
        .conversion_start_n(startN));
    task automatic check(string what, logic [13:0] seen, logic [13:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch %s exp %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic test_done;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : test_done
    task automatic conv(logic c, logic glitch);
        @(posedge clk_sys);
        compareIn <= c;
        sacc_ctl_model_i.convert(glitch, d);
    endtask : conv
    task automatic t_single;
        conv(1'b1, 1'b0);
        check("result", d, 14'h3fff);
        check("valid", fifoValid, 1'b1);
        check("head", fifoData, 14'h3fff);
        $display("single done");
    endtask : t_single
    task automatic t_restart;
        conv(1'b0, 1'b1);
        check("result", d, 14'h0000);
        repeat (25) @(negedge clk_sys);
        check("idle", busy_n, 1'b1);
        $display("restart done");
    endtask : t_restart
    task automatic t_fill;
        logic [13:0] exp [4] = '{14'h3fff, 14'h0, 14'h3fff, 14'h0};
        conv(1'b1, 1'b0);
        conv(1'b0, 1'b0);
        check("overrun", overrun, 1'b0);
        conv(1'b1, 1'b0);
        check("overrun", overrun, 1'b1);
        check("latch", result_bits, 14'h3fff);
        for (int i = 0; i < 4; i++) begin
            @(negedge clk_sys);
            check("head", fifoData, exp[i]);
            check("valid", fifoValid, 1'b1);
            @(posedge clk_sys);
            fifoReady <= 1'b1;
            @(posedge clk_sys);
            fifoReady <= 1'b0;
        end
        @(negedge clk_sys);
        check("empty", fifoValid, 1'b0);
        conv(1'b0, 1'b0);
        check("overrun", overrun, 1'b0);
        $display("fill done");
    endtask : t_fill
    task automatic t_freeze;
        fork
            conv(1'b1, 1'b0);
            begin
                @(negedge busy_n);
                @(posedge clk_sys);
                clkEn <= 1'b0;
                repeat (10) @(posedge clk_sys);
                clkEn <= 1'b1;
                repeat (6) @(negedge clk_sys);
                check("held", busy_n, 1'b0);
            end
        join
        check("frozen", d, 14'h3fff);
        $display("freeze done");
    endtask : t_freeze
    task automatic t_reset;
        @(posedge clk_sys);
        rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        @(negedge clk_sys);
        check("busy", busy_n, 1'b1);
        check("deciding", dacActive, 1'b0);
        check("latch", result_bits, 14'h0000);
        check("empty", fifoValid, 1'b0);
        check("overrun", overrun, 1'b0);
        conv(1'b1, 1'b0);
        check("result", d, 14'h3fff);
        $display("reset done");
    endtask : t_reset
    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end
    initial begin
        #200000;
        n_mismatch++;
        test_done;
    end
    initial begin
        rst = 1'b1;
        clkEn = 1'b1;
        compareIn = 1'b0;
        fifoReady = 1'b0;
        repeat (20) @(posedge clk_sys);
        rst <= 1'b0;
        t_single;
        t_restart;
        t_fill;
        t_freeze;
        t_reset;
        test_done;
    end
endmodule : sar_adc_conversion_control_bench
bind sacc_conv_ctrl sacc_conv_sva sacc_conv_sva_i (.clk_sys, .rst, .clkEn,
    .conversion_start_n, .busy_n, .result_bits, .dacActive, .dacTrial,
    .fifoValid, .overrun);
`default_nettype wire
